/* rtl/remote_control_serial_port.sv */
// remote control serial port: full-duplex UART, RTS/CTS, local/remote mode
// assumes clk_in at 125 MHz; config comes from local panel logic only
`timescale 1ns/1ps
`include "serial_port_params.svh"
module remote_control_serial_port
   import serial_port_pkg::*;
#(
   parameter int FIFO_DEPTH = `FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // local configuration
   input wire line_cfg_s cfg_in,
   // serial pins
   input wire logic rxd_in,
   output logic txd_out,
   output logic rts_out,
   input wire logic cts_in,
   // panel
   input wire logic local_key_in,
   input wire logic [7:0] panel_keys_in,
   output logic [7:0] panel_keys_out,
   output logic remote_led_out,
   // received characters to the parser
   output logic rx_valid_out,
   output logic [7:0] rx_data_out,
   output logic rx_msg_end_out,
   input wire logic rx_ready_in,
   output rx_status_s rx_status_out,
   // response characters from the parser
   input wire logic tx_valid_in,
   input wire logic [7:0] tx_data_in,
   input wire logic tx_last_in,
   output logic tx_ready_out,
   output logic tx_busy_out
);
   // bit period in clock cycles per rate code
   function automatic logic [`DIV_W-1:0] bit_div(input logic [2:0] sel);
      int rate;
      rate = `BASE_BPS << sel;
      return `DIV_W'(`CLK_HZ / rate);
   endfunction : bit_div

   line_cfg_s cfg;
   logic [`DIV_W-1:0] div;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cfg <= '0;
      end else begin
         cfg <= cfg_in;
      end
   end
   assign div = bit_div(cfg.baud_sel);

   // pin synchronisers, three stages, change accepted when stages 2 and 3 agree
   localparam int PINS = 3;
   localparam logic [PINS-1:0] PIN_IDLE = `PIN_IDLE_LEVELS;
   logic [PINS-1:0] pin_raw;
   logic [PINS-1:0] pin_clean;
   logic rx_line;
   logic cts_line;
   logic key_line;
   assign pin_raw = {local_key_in, cts_in, rxd_in};
   for (genvar p = 0; p < PINS; p++) begin : g_pin_sync
      logic [2:0] stage;
      logic clean;
      always_ff @(posedge clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            stage <= PIN_IDLE[p] ? '1 : '0;
            clean <= PIN_IDLE[p];
         end else begin
            stage <= {stage[1:0], pin_raw[p]};
            if (stage[1] == stage[2]) begin
               clean <= stage[2];
            end
         end
      end
      assign pin_clean[p] = clean;
   end
   assign rx_line = pin_clean[0];
   assign cts_line = pin_clean[1];
   assign key_line = pin_clean[2];

   // receiver
   typedef enum logic [4:0] {
      RX_IDLE = 5'b00001, RX_START = 5'b00010, RX_DATA = 5'b00100,
      RX_PAR = 5'b01000, RX_STOP = 5'b10000
   } rx_state_e;
   rx_state_e rx_state;
   logic [`DIV_W-1:0] rx_cnt;
   logic [2:0] rx_bit;
   logic [7:0] rx_shift;
   logic rx_par_bad;
   logic rx_done;
   logic rx_good;
   logic fifo_in_ready;
   logic [$clog2(FIFO_DEPTH+1)-1:0] fifo_level;
   logic [8:0] fifo_head;
   logic [8:0] fifo_word;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rx_state <= RX_IDLE;
         rx_cnt <= '0;
         rx_bit <= '0;
         rx_shift <= '0;
         rx_par_bad <= 1'b0;
         rx_done <= 1'b0;
         rx_good <= 1'b0;
         rx_status_out <= '0;
      end else begin
         rx_done <= 1'b0;
         unique case (rx_state)
            RX_IDLE: begin
               if (!rx_line) begin
                  rx_state <= RX_START;
                  rx_cnt <= div >> 1;
               end
            end
            RX_START: begin
               if (rx_cnt == '0) begin
                  rx_cnt <= div;
                  rx_bit <= '0;
                  rx_par_bad <= 1'b0;
                  rx_state <= rx_line ? RX_IDLE : RX_DATA;
               end else rx_cnt <= rx_cnt - 1'b1;
            end
            RX_DATA: begin
               if (rx_cnt == '0) begin
                  rx_cnt <= div;
                  rx_shift <= {rx_line, rx_shift[7:1]};
                  rx_bit <= rx_bit + 1'b1;
                  if (rx_bit == 3'(`DATA_BITS - 1)) begin
                     rx_state <= (cfg.parity == `PAR_NONE) ? RX_STOP : RX_PAR;
                  end
               end else rx_cnt <= rx_cnt - 1'b1;
            end
            RX_PAR: begin
               if (rx_cnt == '0) begin
                  rx_cnt <= div;
                  rx_par_bad <= (^rx_shift ^ rx_line) != (cfg.parity == `PAR_ODD);
                  rx_state <= RX_STOP;
               end else rx_cnt <= rx_cnt - 1'b1;
            end
            RX_STOP: begin
               // one stop bit is checked; a second is seen as idle line
               if (rx_cnt == '0) begin
                  rx_state <= RX_IDLE;
                  rx_done <= 1'b1;
                  rx_good <= rx_line && !rx_par_bad && fifo_in_ready;
                  rx_status_out.frame_err <= !rx_line;
                  rx_status_out.parity_err <= rx_par_bad;
                  rx_status_out.overrun <= !fifo_in_ready;
               end else rx_cnt <= rx_cnt - 1'b1;
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // receive buffer; bit 8 marks message end
   assign fifo_word = {(rx_shift == `CHAR_LF), rx_shift};
   serial_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) rx_fifo (
      .clk_in(clk_in),
      .rst_n_in(rst_n_in),
      .in_valid_in(rx_done && rx_good),
      .in_data_in(fifo_word),
      .in_ready_out(fifo_in_ready),
      .out_valid_out(rx_valid_out),
      .out_data_out(fifo_head),
      .out_ready_in(rx_ready_in),
      .level_out(fifo_level)
   );
   assign rx_msg_end_out = fifo_head[`DATA_BITS];
   assign rx_data_out = fifo_head[`DATA_BITS-1:0];

   // rts: low once the buffer is nearly full, leaves slack for chars in flight
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rts_out <= 1'b0;
      end else begin
         rts_out <= (32'(fifo_level) + `RTS_SLACK) < FIFO_DEPTH;
      end
   end

   // local/remote mode
   logic remote;
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         remote <= 1'b0;
      end else if (key_line) begin
         remote <= 1'b0;
      end else if (rx_done && rx_good) begin
         remote <= 1'b1;
      end
   end
   assign remote_led_out = remote;
   assign panel_keys_out = remote ? 8'h00 : panel_keys_in;

   // transmitter
   typedef enum logic [4:0] {
      TX_IDLE = 5'b00001, TX_START = 5'b00010, TX_DATA = 5'b00100,
      TX_PAR = 5'b01000, TX_STOP = 5'b10000
   } tx_state_e;
   tx_state_e tx_state;
   logic [`DIV_W-1:0] tx_cnt;
   logic [2:0] tx_bit;
   logic [7:0] tx_shift;
   logic tx_par;
   logic tx_stop2;
   logic [1:0] term_left;
   logic [7:0] next_char;
   logic char_avail;
   assign next_char = (term_left == `TERM_CRLF_CHARS) ? `CHAR_CR : `CHAR_LF;
   assign char_avail = (term_left != 2'h0) || tx_valid_in;
   assign tx_ready_out = (tx_state == TX_IDLE) && cts_line && (term_left == 2'h0);
   assign tx_busy_out = (tx_state != TX_IDLE) || (term_left != 2'h0);
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         tx_state <= TX_IDLE;
         tx_cnt <= '0;
         tx_bit <= '0;
         tx_shift <= '0;
         tx_par <= 1'b0;
         tx_stop2 <= 1'b0;
         term_left <= '0;
         txd_out <= 1'b1;
      end else begin
         unique case (tx_state)
            TX_IDLE: begin
               txd_out <= 1'b1;
               if (char_avail && cts_line) begin
                  tx_state <= TX_START;
                  tx_cnt <= div;
                  txd_out <= 1'b0;
                  if (term_left != 2'h0) begin
                     tx_shift <= next_char;
                     term_left <= term_left - 1'b1;
                  end else begin
                     tx_shift <= tx_data_in;
                     if (tx_last_in) begin
                        term_left <= cfg.line_terminator_select ? `TERM_LF_CHARS
                                                                : `TERM_CRLF_CHARS;
                     end
                  end
               end
            end
            TX_START: begin
               if (tx_cnt == '0) begin
                  tx_cnt <= div;
                  tx_bit <= '0;
                  tx_par <= ^tx_shift ^ (cfg.parity == `PAR_ODD);
                  txd_out <= tx_shift[0];
                  tx_state <= TX_DATA;
               end else tx_cnt <= tx_cnt - 1'b1;
            end
            TX_DATA: begin
               if (tx_cnt == '0) begin
                  tx_cnt <= div;
                  tx_bit <= tx_bit + 1'b1;
                  tx_shift <= {1'b0, tx_shift[7:1]};
                  if (tx_bit == 3'(`DATA_BITS - 1)) begin
                     tx_stop2 <= cfg.two_stop;
                     if (cfg.parity == `PAR_NONE) begin
                        txd_out <= 1'b1;
                        tx_state <= TX_STOP;
                     end else begin
                        txd_out <= tx_par;
                        tx_state <= TX_PAR;
                     end
                  end else txd_out <= tx_shift[1];
               end else tx_cnt <= tx_cnt - 1'b1;
            end
            TX_PAR: begin
               if (tx_cnt == '0) begin
                  tx_cnt <= div;
                  txd_out <= 1'b1;
                  tx_state <= TX_STOP;
               end else tx_cnt <= tx_cnt - 1'b1;
            end
            TX_STOP: begin
               if (tx_cnt == '0) begin
                  tx_cnt <= div;
                  if (tx_stop2) tx_stop2 <= 1'b0;
                  else tx_state <= TX_IDLE;
               end else tx_cnt <= tx_cnt - 1'b1;
            end
            default: tx_state <= TX_IDLE;
         endcase
      end
   end
   // dcd, dtr, dsr and ri have no port at all
endmodule : remote_control_serial_port

module serial_fifo #(
   parameter int WIDTH = `DATA_BITS,
   parameter int DEPTH = `FIFO_DEPTH
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // fill side
   input wire logic in_valid_in,
   input wire logic [WIDTH-1:0] in_data_in,
   output logic in_ready_out,
   // drain side
   output logic out_valid_out,
   output logic [WIDTH-1:0] out_data_out,
   input wire logic out_ready_in,
   // fill level
   output logic [$clog2(DEPTH+1)-1:0] level_out
);
   localparam int AW = $clog2(DEPTH);
   localparam int CW = $clog2(DEPTH + 1);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_ptr;
   logic [AW-1:0] rd_ptr;
   logic [CW-1:0] count;
   logic push;
   logic pop;
   assign in_ready_out = (count != CW'(DEPTH));
   assign out_valid_out = (count != '0);
   assign push = in_valid_in && in_ready_out;
   assign pop = out_valid_out && out_ready_in;
   assign out_data_out = mem[rd_ptr];
   assign level_out = count;
   always_ff @(posedge clk_in) begin
      if (push) begin
         mem[wr_ptr] <= in_data_in;
      end
   end
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count <= '0;
      end else begin
         if (push) begin
            wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
         end
         count <= count + CW'(push) - CW'(pop);
      end
   end
endmodule : serial_fifo

/* rtl/serial_fifo.sv */
// holds no logic; the flip-flop receive FIFO sits beside the serial port module
// assumes remote_control_serial_port.sv is in the same design file list

/* rtl/serial_port_params.svh */
// constants for the remote control serial port
// assumes a 125 MHz system clock
`ifndef SERIAL_PORT_PARAMS_SVH
`define SERIAL_PORT_PARAMS_SVH
`define CLK_HZ 125000000
`define DATA_BITS 8
`define CHAR_CR 8'h0D
`define CHAR_LF 8'h0A
`define FIFO_DEPTH 8
`define RTS_SLACK 2
`define BAUD_SEL_W 3
`define DIV_W 20
`define PAR_NONE 2'h0
`define PAR_EVEN 2'h1
`define PAR_ODD 2'h2
`define BASE_BPS 300
`define TERM_CRLF_CHARS 2'h2
`define TERM_LF_CHARS 2'h1
`define PIN_IDLE_LEVELS 3'h1
`endif

/* rtl/serial_port_pkg.sv */
// types for the remote control serial port
// assumes serial_port_params.svh is on the include path
`include "serial_port_params.svh"
package serial_port_pkg;
   typedef struct packed {
      logic [2:0] baud_sel;
      logic [1:0] parity;
      logic two_stop;
      logic line_terminator_select;
   } line_cfg_s;
   typedef struct packed {
      logic overrun;
      logic parity_err;
      logic frame_err;
   } rx_status_s;
endpackage : serial_port_pkg

/* tb/remote_control_serial_port_properties.sv */
// assertions on the serial port top-level ports
// assumes bind into remote_control_serial_port, single clock domain
`timescale 1ns/1ps
`include "serial_port_params.svh"
module serial_port_checker (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_n_in,
   // serial pins
   input wire logic txd_out,
   input wire logic rts_out,
   input wire logic cts_in,
   // panel
   input wire logic local_key_in,
   input wire logic [7:0] panel_keys_in,
   input wire logic [7:0] panel_keys_out,
   input wire logic remote_led_out,
   // parser sides
   input wire logic rx_valid_out,
   input wire logic [7:0] rx_data_out,
   input wire logic rx_msg_end_out,
   input wire logic tx_valid_in,
   input wire logic tx_ready_out,
   input wire logic tx_busy_out
);
   logic [3:0] key_age;
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // cycles since the local key was last seen high
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) key_age <= 4'hF;
      else if (local_key_in) key_age <= 4'h0;
      else if (key_age != 4'hF) key_age <= key_age + 4'h1;
   end
   AST_LOCAL_AT_START: assert property ($rose(rst_n_in) |-> !remote_led_out && txd_out)
      else $error("not local and idle after reset");
   AST_PANEL_MASKED: assert property (remote_led_out |-> panel_keys_out == 8'h00)
      else $error("panel keys pass in remote");
   AST_PANEL_PASS: assert property (!remote_led_out |-> panel_keys_out == panel_keys_in)
      else $error("panel keys blocked in local");
   AST_KEY_FORCES_LOCAL: assert property (local_key_in [*8] |-> !remote_led_out)
      else $error("local key ignored");
   AST_LEAVE_ONLY_BY_KEY: assert property ($fell(remote_led_out) |-> key_age < 4'h8)
      else $error("left remote without local key");
   AST_CTS_HOLDS_TX: assert property (!cts_in [*6] |-> !tx_ready_out)
      else $error("tx ready while cts low");
   AST_START_BIT: assert property (tx_valid_in && tx_ready_out |=> !txd_out && tx_busy_out)
      else $error("no start bit after take");
   AST_IDLE_LINE: assert property (!tx_busy_out |-> txd_out)
      else $error("line not idle while not busy");
   AST_RTS_WHEN_EMPTY: assert property (!rx_valid_out [*4] |-> rts_out)
      else $error("rts low with empty buffer");
   AST_MSG_END: assert property (rx_valid_out |-> rx_msg_end_out == (rx_data_out == `CHAR_LF))
      else $error("message end flag wrong");
   cover property ($rose(remote_led_out));
   cover property ($fell(remote_led_out));
   cover property (tx_valid_in && tx_ready_out);
   cover property (rx_valid_out && rx_msg_end_out);
endmodule : serial_port_checker

bind remote_control_serial_port serial_port_checker i_serial_port_checker (
   .clk_in(clk_in), .rst_n_in(rst_n_in), .txd_out(txd_out), .rts_out(rts_out),
   .cts_in(cts_in), .local_key_in(local_key_in), .panel_keys_in(panel_keys_in),
   .panel_keys_out(panel_keys_out), .remote_led_out(remote_led_out),
   .rx_valid_out(rx_valid_out), .rx_data_out(rx_data_out), .rx_msg_end_out(rx_msg_end_out),
   .tx_valid_in(tx_valid_in), .tx_ready_out(tx_ready_out), .tx_busy_out(tx_busy_out)
);

/* tb/remote_control_serial_port_test.sv */
// self-checking bench for the remote control serial port
// assumes serial_host_model at the serial pins, 38400 bps even parity
// three-word receive buffer, so one held character drops rts
`timescale 1ns/1ps
`include "serial_port_params.svh"
module remote_control_serial_port_test
   import serial_port_pkg::*;
;
   localparam int BIT = `CLK_HZ / 38400 + 1;
   logic clk_in, rst_n_in, rxd, txd, rts, cts, local_key, led;
   logic rx_valid, msg_end, rx_ready, tx_valid, tx_last, tx_ready, tx_busy;
   logic [7:0] panel_in, panel_out, rx_data, tx_data;
   line_cfg_s cfg;
   rx_status_s status;
   int failures, checked;
   remote_control_serial_port #(.FIFO_DEPTH(3)) i_remote_control_serial_port (
      .clk_in(clk_in), .rst_n_in(rst_n_in), .cfg_in(cfg), .rxd_in(rxd), .txd_out(txd),
      .rts_out(rts), .cts_in(cts), .local_key_in(local_key), .panel_keys_in(panel_in),
      .panel_keys_out(panel_out), .remote_led_out(led), .rx_valid_out(rx_valid),
      .rx_data_out(rx_data), .rx_msg_end_out(msg_end), .rx_ready_in(rx_ready),
      .rx_status_out(status), .tx_valid_in(tx_valid), .tx_data_in(tx_data),
      .tx_last_in(tx_last), .tx_ready_out(tx_ready), .tx_busy_out(tx_busy)
   );
   serial_host_model #(.BIT(BIT)) i_serial_host_model (
      .clk_in(clk_in), .dev_txd_in(txd), .dev_rxd_out(rxd), .dev_rts_in(rts), .dev_cts_out(cts)
   );
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic stop_test();
      if (failures == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : stop_test
   task automatic test_after_reset();
      repeat (6) @(posedge clk_in);
      #1 check("txd idle", txd, 1'h1);
      check("rts with space", rts, 1'h1);
      check("led at start", led, 1'h0);
      check("panel in local", panel_out, 8'hA5);
   endtask : test_after_reset
   // cts hold-off, then a response sent while a byte comes in
   task automatic test_duplex();
      logic [10:0] f1, f2;
      logic seen;
      int n;
      i_serial_host_model.set_cts(1'b0);
      repeat (8) @(posedge clk_in);
      #1 tx_data = 8'h41;
      tx_last = 1'b1;
      tx_valid = 1'b1;
      seen = 1'b0;
      repeat (30) begin
         @(posedge clk_in);
         #1 seen = seen | tx_ready | !txd;
      end
      check("tx while cts low", seen, 1'h0);
      i_serial_host_model.set_cts(1'b1);
      n = 0;
      while (tx_ready !== 1'b1 && n < 20) begin
         @(posedge clk_in);
         #1 n++;
      end
      check("tx resumes", n < 20, 1'h1);
      fork
         begin
            @(posedge clk_in);
            #1 tx_valid = 1'b0;
            i_serial_host_model.recv(f1);
            i_serial_host_model.recv(f2);
         end
         i_serial_host_model.send(`CHAR_LF);
      join
      @(posedge clk_in);
      #1 check("frame data", f1, {1'b1, ^8'h41, 8'h41, 1'b0});
      check("frame term", f2, {1'b1, ^`CHAR_LF, `CHAR_LF, 1'b0});
      check("rx valid", rx_valid, 1'h1);
      check("rx data", rx_data, `CHAR_LF);
      check("rx end", msg_end, 1'h1);
      check("led remote", led, 1'h1);
      check("panel masked", panel_out, 8'h00);
      check("rx status", status, 3'h0);
      check("rts held off", rts, 1'h0);
      rx_ready = 1'b1;
      @(posedge clk_in);
      #1 rx_ready = 1'b0;
      check("rx popped", rx_valid, 1'h0);
      @(posedge clk_in);
      #1 check("rts released", rts, 1'h1);
   endtask : test_duplex
   task automatic test_local_key();
      local_key = 1'b1;
      repeat (10) @(posedge clk_in);
      #1 local_key = 1'b0;
      check("led after key", led, 1'h0);
      check("panel after key", panel_out, 8'hA5);
      repeat (10) @(posedge clk_in);
      #1 check("stays local", led, 1'h0);
   endtask : test_local_key
   initial begin
      clk_in = 1'b0;
      forever #4 clk_in = ~clk_in;
   end
   initial begin
      repeat (95000) @(posedge clk_in);
      failures++;
      stop_test();
   end
   initial begin
      cfg = '{baud_sel: 3'h7, parity: `PAR_EVEN, two_stop: 1'b0, line_terminator_select: 1'b1};
      rst_n_in = 1'b0;
      local_key = 1'b0;
      panel_in = 8'hA5;
      rx_ready = 1'b0;
      tx_valid = 1'b0;
      tx_last = 1'b0;
      tx_data = 8'h00;
      failures = 0;
      checked = 0;
      repeat (8) @(posedge clk_in);
      #1 rst_n_in = 1'b1;
      test_after_reset();
      test_duplex();
      test_local_key();
      stop_test();
   end
endmodule : remote_control_serial_port_test

/* tb/serial_host_model.sv */
// behavioural far-end computer on a cross cable
// assumes even parity, one stop bit, bit time given in clocks
`timescale 1ns/1ps
module serial_host_model #(
   parameter int BIT = 3256
) (
   // clock
   input wire logic clk_in,
   // data lines
   input wire logic dev_txd_in,
   output logic dev_rxd_out,
   // flow control
   input wire logic dev_rts_in,
   output logic dev_cts_out
);
   initial begin
      dev_rxd_out = 1'b1;
      dev_cts_out = 1'b1;
   end
   task automatic set_cts(input logic level);
      dev_cts_out = level;
   endtask : set_cts
   task automatic send(input logic [7:0] d);
      logic [10:0] f;
      int n;
      f = {1'b1, ^d, d, 1'b0};
      n = 0;
      while (!dev_rts_in && n < 200000) begin
         @(posedge clk_in);
         n++;
      end
      for (int i = 0; i < 11; i++) begin
         #1 dev_rxd_out = f[i];
         repeat (BIT) @(posedge clk_in);
      end
   endtask : send
   // samples start, data, parity and stop at mid-bit
   task automatic recv(output logic [10:0] f);
      int n;
      n = 0;
      while (dev_txd_in !== 1'b0 && n < 200000) begin
         @(posedge clk_in);
         n++;
      end
      repeat (BIT / 2) @(posedge clk_in);
      for (int i = 0; i < 11; i++) begin
         f[i] = dev_txd_in;
         if (i < 10) repeat (BIT) @(posedge clk_in);
      end
   endtask : recv
endmodule : serial_host_model
